// ---- src/pcmtf_cfg.svh ----
`ifndef PCMTF_CFG_SVH
`define PCMTF_CFG_SVH

// frame geometry
`define PCMTF_WORD_BITS      8
`define PCMTF_MINOR_WORDS    50
`define PCMTF_MAJOR_MINORS   16
`define PCMTF_MAJOR_RATE_HZ  10
`define PCMTF_LAST_WORD      6'h31
`define PCMTF_LAST_MINOR     4'hF

// pacing: bit rate follows from the major frame rate
`define PCMTF_CLK_HZ         125000000
`define PCMTF_BIT_RATE_HZ    (`PCMTF_MAJOR_RATE_HZ * `PCMTF_MAJOR_MINORS * `PCMTF_MINOR_WORDS * `PCMTF_WORD_BITS)
`define PCMTF_HALF_RATE_HZ   (2 * `PCMTF_BIT_RATE_HZ)

// fixed words and their positions (word index counts from 0)
`define PCMTF_SYNC1          8'hFA
`define PCMTF_SYNC2          8'hF3
`define PCMTF_SYNC3          8'h20
`define PCMTF_ID_WORD        6'h03
`define PCMTF_FIRST_DATA     6'h04

// commutation map
`define PCMTF_SUPER_A        6'h04
`define PCMTF_SUPER_B        6'h1B
`define PCMTF_SUPER_N        6'h04
`define PCMTF_COMM_A_END     6'h17
`define PCMTF_COMM_B         6'h1F
`define PCMTF_COMM_B_CHAN    8'h14
`define PCMTF_SUB80_WORD     6'h18
`define PCMTF_SUB80_BASE     8'h26
`define PCMTF_SUB40_WORD     6'h19
`define PCMTF_SUB40_BASE     8'h28
`define PCMTF_SUB20_WORD     6'h1A
`define PCMTF_SUB20_BASE     8'h2C
`define PCMTF_SUB10_WORD     6'h31
`define PCMTF_SUB10_BASE     8'h34

// converter transfer
`define PCMTF_LOW_MV         (-60)
`define PCMTF_MV_PER_COUNT   20
`define PCMTF_FULL_COUNT     8'hFF

// sample buffer
`define PCMTF_FIFO_DEPTH     16

`endif

// ---- src/pcmtf_pkg.sv ----
package pcmtf_pkg;
  typedef logic [7:0]         pcmtf_word_t;
  typedef logic signed [15:0] pcmtf_mv_t;
  typedef enum logic [1:0] {PCMTF_SLOT_SYNC, PCMTF_SLOT_ID, PCMTF_SLOT_DATA} pcmtf_slot_t;
endpackage

// ---- src/pcmtf_fifo_if.sv ----
`timescale 1ns/1ps
interface pcmtf_fifo_if #(parameter int W = 8);
  logic         in_valid;
  logic         in_ready;
  logic [W-1:0] in_data;
  logic         out_valid;
  logic         out_ready;
  logic [W-1:0] out_data;
  modport buf_side  (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
  modport user_side (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface

// ---- src/pcmtf_fifo.sv ----
`timescale 1ns/1ps
module pcmtf_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic         sys_clk,
  input  wire logic         resetn,
  pcmtf_fifo_if.buf_side    q
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   count;
  logic [AW:0]   next_count;
  logic          push;
  logic          pop;

  assign push       = q.in_valid && q.in_ready;
  assign pop        = q.out_valid && q.out_ready;
  assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  assign q.out_valid = (count != '0);
  assign q.out_data  = mem[rd_ptr];

  // storage has no reset so it maps onto plain ram
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= q.in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= AW'(wr_ptr + 1'b1);
      end
      if (pop) begin
        rd_ptr <= AW'(rd_ptr + 1'b1);
      end
      count <= next_count;
    end
  end

  // ready is registered so the source sees a clean level
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      q.in_ready <= 1'b0;
    end else begin
      q.in_ready <= (next_count != (AW+1)'(DEPTH));
    end
  end
endmodule

// ---- src/pcmtf_top.sv ----
`timescale 1ns/1ps
`include "pcmtf_cfg.svh"
// Overview of operation
// RULE_01: each telemetry word is exactly eight plain bits with no parity or sign bit.
// RULE_02: minor frames are exactly fifty words long and follow each other without gaps.
// RULE_03: sixteen minor frames form a major frame, then the sequence restarts at minor frame one.
// RULE_04: pacing is derived so that exactly ten major frames go out every second.
// RULE_05: words one to three of every minor frame are the sync patterns FA, F3 and 20 hex.
// RULE_06: word four carries the minor frame number, zero in the first and fifteen in the last.
// RULE_07: the minor frame number sits in the four low bits of its word.
// RULE_08: channels go once or twice per minor frame, or every 2, 4, 8 or 16 minor frames.
// RULE_09: an input at or below minus sixty millivolts converts to the all-zero count.
// RULE_10: an input above the top of the range saturates at the all-ones count.
// RULE_11: the stream leaves as biphase-level Manchester code at 64 kbit/s.
// RULE_12: the upper four bits of the minor frame number word are zero.
module pcmtf_top (
  input  wire logic                sys_clk,
  input  wire logic                resetn,
  input  wire logic                samp_valid,
  input  wire pcmtf_pkg::pcmtf_mv_t samp_mv,
  output wire logic                samp_ready,
  output logic                     chan_req_valid,
  output logic [7:0]               chan_req_id,
  output logic                     pcm_line,
  output logic                     word_strobe,
  output logic                     frame_start,
  output logic                     underrun
);
  import pcmtf_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  // where a word index falls inside the minor frame
  function automatic pcmtf_slot_t slot_of(input logic [5:0] w);
    if (w < `PCMTF_ID_WORD) begin
      return PCMTF_SLOT_SYNC;
    end else if (w == `PCMTF_ID_WORD) begin
      return PCMTF_SLOT_ID;
    end
    return PCMTF_SLOT_DATA;
  endfunction

  // channel carried by a data word in a given minor frame
  function automatic logic [7:0] chan_of(input logic [5:0] w, input logic [3:0] mf);
    logic [7:0] w8;
    w8 = {2'h0, w};
    if (w >= `PCMTF_SUPER_A && w < `PCMTF_SUPER_A + `PCMTF_SUPER_N) begin
      return 8'(w8 - {2'h0, `PCMTF_SUPER_A});
    end else if (w >= `PCMTF_SUPER_B && w < `PCMTF_SUPER_B + `PCMTF_SUPER_N) begin
      return 8'(w8 - {2'h0, `PCMTF_SUPER_B});
    end else if (w <= `PCMTF_COMM_A_END) begin
      return 8'(w8 - {2'h0, `PCMTF_SUPER_A});
    end else if (w == `PCMTF_SUB80_WORD) begin
      return 8'(`PCMTF_SUB80_BASE + {7'h00, mf[0]});
    end else if (w == `PCMTF_SUB40_WORD) begin
      return 8'(`PCMTF_SUB40_BASE + {6'h00, mf[1:0]});
    end else if (w == `PCMTF_SUB20_WORD) begin
      return 8'(`PCMTF_SUB20_BASE + {5'h00, mf[2:0]});
    end else if (w == `PCMTF_SUB10_WORD) begin
      return 8'(`PCMTF_SUB10_BASE + {4'h0, mf});
    end
    return 8'(w8 - {2'h0, `PCMTF_COMM_B} + `PCMTF_COMM_B_CHAN);
  endfunction

  // millivolts to an 8-bit count, clamped at both ends
  function automatic pcmtf_word_t convert(input pcmtf_mv_t mv);
    logic signed [17:0] shifted;
    logic [17:0]        q;
    shifted = 18'(mv) - 18'(`PCMTF_LOW_MV);
    q       = 18'(shifted / 18'(`PCMTF_MV_PER_COUNT));
    // RULE_09 low end clamp
    if (shifted <= 18'sh0) begin
      return 8'h00;
    // RULE_10 high end saturation
    end else if (q > 18'h000FF) begin
      return `PCMTF_FULL_COUNT;
    end
    return q[7:0];
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // sample intake: request walker, converter, buffer

  pcmtf_fifo_if #(.W(8)) buf_q ();

  logic [5:0] req_word;
  logic [3:0] req_minor;
  logic       accept;
  logic [5:0] next_req_word;
  logic [3:0] next_req_minor;
  pcmtf_word_t conv_word;

  assign conv_word      = convert(samp_mv);
  assign buf_q.in_valid = samp_valid && chan_req_valid;
  assign buf_q.in_data  = conv_word;
  assign samp_ready     = buf_q.in_ready;
  assign accept         = buf_q.in_valid && buf_q.in_ready;

  // walk the data slots only; sync and id words never come from the source
  always_comb begin
    next_req_word  = req_word;
    next_req_minor = req_minor;
    if (accept) begin
      if (req_word == `PCMTF_LAST_WORD) begin
        next_req_word  = `PCMTF_FIRST_DATA;
        next_req_minor = 4'(req_minor + 1'b1);
      end else begin
        next_req_word = 6'(req_word + 1'b1);
      end
    end
  end

  // RULE_08 channel request order
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      req_word       <= `PCMTF_FIRST_DATA;
      req_minor      <= 4'h0;
      chan_req_valid <= 1'b0;
      chan_req_id    <= 8'h00;
    end else begin
      req_word       <= next_req_word;
      req_minor      <= next_req_minor;
      chan_req_valid <= 1'b1;
      chan_req_id    <= chan_of(next_req_word, next_req_minor);
    end
  end

  pcmtf_fifo #(
    .W     (8),
    .DEPTH (`PCMTF_FIFO_DEPTH)
  ) u_buf (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .q       (buf_q)
  );

  //////////////////////////////////////////////////////////////////////////////
  // half-bit pacing

  logic [26:0] acc;
  logic [27:0] acc_sum;
  logic        tick;

  assign acc_sum = {1'b0, acc} + 28'(`PCMTF_HALF_RATE_HZ);

  // RULE_04 fractional divider
  // the clock is not a multiple of the bit rate, so a phase accumulator keeps the
  // long-term rate exact at the cost of one cycle of jitter per half bit
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      acc  <= 27'h0;
      tick <= 1'b0;
    end else if (acc_sum >= 28'(`PCMTF_CLK_HZ)) begin
      acc  <= 27'(acc_sum - 28'(`PCMTF_CLK_HZ));
      tick <= 1'b1;
    end else begin
      acc  <= acc_sum[26:0];
      tick <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // frame builder and line coder

  logic        half;
  logic [2:0]  bit_idx;
  logic [5:0]  word_idx;
  logic [3:0]  minor;
  pcmtf_word_t sh;
  logic        word_load;
  logic [5:0]  nw_idx;
  logic [3:0]  nw_minor;
  pcmtf_word_t next_word;

  // RULE_01 eight bits per word
  assign word_load = tick && half && (bit_idx == 3'h7);

  // RULE_02 gapless fifty-word frames
  // RULE_03 sixteen minors then restart
  always_comb begin
    nw_idx   = 6'(word_idx + 1'b1);
    nw_minor = minor;
    if (word_idx == `PCMTF_LAST_WORD) begin
      nw_idx   = 6'h00;
      nw_minor = 4'(minor + 1'b1);
    end
  end

  // pick the next word; an empty buffer sends zero rather than stall the line
  always_comb begin
    buf_q.out_ready = 1'b0;
    next_word       = 8'h00;
    case (slot_of(nw_idx))
      PCMTF_SLOT_SYNC: begin
        // RULE_05 sync pattern order
        case (nw_idx[1:0])
          2'h0:    next_word = `PCMTF_SYNC1;
          2'h1:    next_word = `PCMTF_SYNC2;
          default: next_word = `PCMTF_SYNC3;
        endcase
      end
      PCMTF_SLOT_ID: begin
        // RULE_06 minor frame number
        // RULE_07 number in low nibble
        // RULE_12 upper nibble zero
        next_word = {4'h0, nw_minor};
      end
      PCMTF_SLOT_DATA: begin
        buf_q.out_ready = word_load;
        next_word       = buf_q.out_valid ? buf_q.out_data : 8'h00;
      end
      default: begin
        next_word = 8'h00;
      end
    endcase
  end

  // bit and word sequencing
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      half     <= 1'b0;
      bit_idx  <= 3'h0;
      word_idx <= 6'h00;
      minor    <= 4'h0;
      sh       <= `PCMTF_SYNC1;
    end else if (tick) begin
      half <= ~half;
      if (half) begin
        if (bit_idx == 3'h7) begin
          bit_idx  <= 3'h0;
          word_idx <= nw_idx;
          minor    <= nw_minor;
          sh       <= next_word;
        end else begin
          bit_idx <= 3'(bit_idx + 1'b1);
          sh      <= {sh[6:0], 1'b0};
        end
      end
    end
  end

  // RULE_11 biphase-level coding
  // msb first: a one is high then low, a zero low then high, so every bit has a
  // mid-cell edge the receiver can lock to
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pcm_line <= 1'b0;
    end else if (tick) begin
      pcm_line <= half ? ~sh[7] : sh[7];
    end
  end

  // framing markers and the sticky starvation flag
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      word_strobe <= 1'b0;
      frame_start <= 1'b0;
      underrun    <= 1'b0;
    end else begin
      word_strobe <= word_load;
      frame_start <= word_load && (nw_idx == 6'h00);
      if (word_load && slot_of(nw_idx) == PCMTF_SLOT_DATA && !buf_q.out_valid) begin
        underrun <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks

  word_bits_a: assert property ( // RULE_01
    @(posedge sys_clk) disable iff (!resetn)
    (tick && half && bit_idx != 3'h7) |=> (word_idx == $past(word_idx)))
    else $error("word advanced before eight bits");

  frame_length_a: assert property ( // RULE_02
    @(posedge sys_clk) disable iff (!resetn)
    word_idx <= `PCMTF_LAST_WORD)
    else $error("word index past end of minor frame");

  minor_wrap_a: assert property ( // RULE_03
    @(posedge sys_clk) disable iff (!resetn)
    (word_load && word_idx == `PCMTF_LAST_WORD)
      |=> (word_idx == 6'h00 && minor == 4'($past(minor) + 1'b1)))
    else $error("minor frame did not advance at frame end");

  tick_spacing_a: assert property ( // RULE_04
    @(posedge sys_clk) disable iff (!resetn)
    tick |=> !tick [*8])
    else $error("half-bit ticks too close");

  sync_first_a: assert property ( // RULE_05
    @(posedge sys_clk) disable iff (!resetn)
    (word_load && nw_idx < `PCMTF_ID_WORD)
      |=> ((word_idx == $past(nw_idx)) &&
           (sh == ((word_idx == 6'h00) ? `PCMTF_SYNC1 :
                   (word_idx == 6'h01) ? `PCMTF_SYNC2 : `PCMTF_SYNC3))))
    else $error("sync word out of place");

  id_word_a: assert property ( // RULE_06
    @(posedge sys_clk) disable iff (!resetn)
    (word_load && nw_idx == `PCMTF_ID_WORD) |=> (sh == {4'h0, minor}))
    else $error("minor frame number word wrong");

  sub10_chan_a: assert property ( // RULE_08
    @(posedge sys_clk) disable iff (!resetn)
    (chan_req_valid && req_word == `PCMTF_SUB10_WORD)
      |-> (chan_req_id == 8'(`PCMTF_SUB10_BASE + {4'h0, req_minor})))
    else $error("slowest subcommutated channel mismatched");

  comm_chan_a: assert property ( // RULE_08
    @(posedge sys_clk) disable iff (!resetn)
    (chan_req_valid && req_word >= `PCMTF_FIRST_DATA && req_word <= `PCMTF_COMM_A_END)
      |-> (chan_req_id == {2'h0, 6'(req_word - `PCMTF_FIRST_DATA)}))
    else $error("once-per-frame channel mismatched");

  low_clamp_a: assert property ( // RULE_09
    @(posedge sys_clk) disable iff (!resetn)
    (samp_mv <= 16'sd0 - 16'sd60) |-> (conv_word == 8'h00))
    else $error("low input not converted to zero");

  high_clamp_a: assert property ( // RULE_10
    @(posedge sys_clk) disable iff (!resetn)
    (samp_mv > 16'sd5060) |-> (conv_word == `PCMTF_FULL_COUNT))
    else $error("high input not saturated");

  mid_edge_a: assert property ( // RULE_11
    @(posedge sys_clk) disable iff (!resetn)
    (tick && half) |=> (pcm_line != $past(pcm_line)))
    else $error("no mid-bit transition");
endmodule

// ---- verification/pcmtf_decom.sv ----
`timescale 1ns/1ps
// ground decommutator model: its time base starts with the framer's divider at reset
// release, since the first word leaves without a strobe; it then samples each
// half-bit near its centre; a half-bit lasts 125e6/128000 = 976.5625 cycles
module pcmtf_decom (
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  input  wire logic              pcm_line,
  output pcmtf_pkg::pcmtf_word_t rx_word,
  output logic                   rx_valid,
  output logic                   code_err
);
  import pcmtf_pkg::*;

  logic        locked;
  int          cnt;
  int          half;
  int          next_pt;
  logic        first_half;
  pcmtf_word_t shreg;

  //////////////////////////////////////////////////////////////////////////////
  // centre of half-bit number half; the exact ratio keeps long runs free of drift
  assign next_pt = 1464 + (half * 15625) / 16;

  // sampler and word assembly, msb first
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      locked     <= 1'b0;
      cnt        <= 0;
      half       <= 0;
      first_half <= 1'b0;
      shreg      <= 8'h00;
      rx_word    <= 8'h00;
      rx_valid   <= 1'b0;
      code_err   <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (!locked) begin
        locked <= 1'b1;
        cnt    <= 0;
      end else begin
        cnt <= cnt + 1;
        if (cnt == next_pt) begin
          half <= half + 1;
          if (half[0] == 1'b0) begin
            first_half <= pcm_line;
          end else begin
            if (pcm_line == first_half) code_err <= 1'b1;
            shreg <= {shreg[6:0], first_half};
          end
          if (half[3:0] == 4'hF) begin
            rx_word  <= {shreg[6:0], first_half};
            rx_valid <= 1'b1;
          end
        end
      end
    end
  end
endmodule

// ---- verification/pcm_telemetry_frame_multiplexer_tb.sv ----
`timescale 1ns/1ps
module pcm_telemetry_frame_multiplexer_tb;
  import pcmtf_pkg::*;

  logic        sys_clk;
  logic        resetn;
  logic        samp_valid;
  pcmtf_mv_t   samp_mv;
  logic        samp_ready;
  logic        chan_req_valid;
  logic [7:0]  chan_req_id;
  logic        pcm_line;
  logic        word_strobe;
  logic        frame_start;
  logic        underrun;
  pcmtf_word_t rx_word;
  logic        rx_valid;
  logic        code_err;
  int          miscompares = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          last_strobe = 0;
  int          n_strobe = 0;
  pcmtf_word_t got[$];
  // sync 1..3, minor id 0, channel 0 at -100 mV, channel 1 at 6000 mV
  pcmtf_word_t exp_w[6] = '{8'hFA, 8'hF3, 8'h20, 8'h00, 8'h00, 8'hFF};

  //////////////////////////////////////////////////////////////////////////////
  pcmtf_top dut (
    .sys_clk        (sys_clk),
    .resetn         (resetn),
    .samp_valid     (samp_valid),
    .samp_mv        (samp_mv),
    .samp_ready     (samp_ready),
    .chan_req_valid (chan_req_valid),
    .chan_req_id    (chan_req_id),
    .pcm_line       (pcm_line),
    .word_strobe    (word_strobe),
    .frame_start    (frame_start),
    .underrun       (underrun)
  );

  pcmtf_decom decom (
    .sys_clk     (sys_clk),
    .resetn      (resetn),
    .pcm_line    (pcm_line),
    .rx_word     (rx_word),
    .rx_valid    (rx_valid),
    .code_err    (code_err)
  );

  //////////////////////////////////////////////////////////////////////////////
  task automatic fail(input string m);
    miscompares++;
    $display("unexpected at %0t: %s", $time, m);
  endtask

  function automatic bit bad(input bit b);
    n_checks++;
    return b;
  endfunction

  task automatic close_out;
    if (miscompares == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // offer one sample; ready is read at the falling edge since it only moves on rising ones
  task automatic offer(input pcmtf_mv_t mv, input logic [7:0] id, input int tries,
                       output bit took);
    took = 1'b0;
    samp_valid <= 1'b1;
    samp_mv    <= mv;
    repeat (tries) begin
      @(negedge sys_clk);
      if (samp_ready === 1'b1 && chan_req_valid === 1'b1) begin
        took = 1'b1;
        if (bad(chan_req_id !== id)) fail("channel order");
      end
      @(posedge sys_clk);
      if (took) break;
    end
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // clock and time base
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // strobe spacing and captured words, watched at the settled falling edge
  always @(negedge sys_clk) begin
    cyc++;
    if (resetn === 1'b1 && word_strobe === 1'b1) begin
      if (n_strobe > 0 && bad(cyc - last_strobe != 15625)) fail("word spacing");
      // the first strobe loads word one, so word zero comes with every fiftieth strobe
      if (bad(frame_start !== (n_strobe % 50 == 49))) fail("frame start");
      last_strobe = cyc;
      n_strobe++;
    end
    if (rx_valid === 1'b1) got.push_back(rx_word);
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    @(negedge sys_clk);
    if (bad({samp_ready, chan_req_valid, pcm_line, word_strobe, frame_start, underrun}
            !== 6'h00)) fail("outputs in reset");
    @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    @(negedge sys_clk);
    if (bad(chan_req_valid !== 1'b1 || chan_req_id !== 8'h00)) fail("first request");
    if (bad(samp_ready !== 1'b1)) fail("ready after reset");
    @(posedge sys_clk);
  endtask

  // sixteen back-to-back samples fill the buffer, the seventeenth must wait
  task automatic t_fill;
    bit        took;
    pcmtf_mv_t mv;
    for (int i = 0; i < 16; i++) begin
      mv = pcmtf_mv_t'(20 * i);
      if (i == 0) mv = -16'sd100;
      if (i == 1) mv = 16'sd6000;
      offer(mv, 8'(i), 4, took);
      if (bad(took !== 1'b1)) fail("sample refused");
    end
    offer(16'sd0, 8'h10, 6, took);
    if (bad(took !== 1'b0 || samp_ready !== 1'b0)) fail("full buffer took sample");
    samp_valid <= 1'b0;
  endtask

  // after the slot-4 pop one more sample fits; then the first six words are judged
  task automatic t_stream;
    bit took;
    for (int k = 0; k < 90000 && n_strobe < 5; k++) @(posedge sys_clk);
    repeat (4) @(posedge sys_clk);
    offer(16'sd320, 8'h10, 4, took);
    if (bad(took !== 1'b1)) fail("no room after pop");
    samp_valid <= 1'b0;
    for (int k = 0; k < 40000 && got.size() < 6; k++) @(posedge sys_clk);
    if (bad(got.size() != 6)) fail("words missing");
    for (int k = 0; k < 6 && k < got.size(); k++) begin
      if (bad(got[k] !== exp_w[k])) fail("word value");
    end
    if (bad(code_err !== 1'b0 || underrun !== 1'b0)) fail("line code or underrun");
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // main sequence; reset held ten cycles
  initial begin
    resetn     = 1'b0;
    samp_valid = 1'b0;
    samp_mv    = 16'sh0000;
    repeat (10) @(posedge sys_clk);
    t_reset;
    t_fill;
    t_stream;
    close_out;
  end

  // watchdog: six words take about 94.2k cycles after reset release
  initial begin
    repeat (100000) @(posedge sys_clk);
    fail("timeout");
    close_out;
  end
endmodule
